// file: logic/uef_pkg.sv
// Purpose: shared constants for the endpoint and frame register block
// Assumes: 8-bit register port, 100 MHz clock
// Notes: offsets are byte addresses on the register port
package uef_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_EP = 3;
    localparam int FRAME_W = 11;
    localparam int BYCT_W = 7;
    localparam int DIV_W = 2;
    localparam int FIFO_DEPTH = 64;
    localparam real CLK_PERIOD_NS = 10.0;
    // register offsets
    localparam logic [7:0] OFS_FRAME_LOW = 8'hba;
    localparam logic [7:0] OFS_FRAME_HIGH = 8'hbb;
    localparam logic [7:0] OFS_EP_IRQ_ENABLE = 8'hc2;
    localparam logic [7:0] OFS_EP_SELECT = 8'hc7;
    localparam logic [7:0] OFS_FIFO_WINDOW = 8'hcf;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'hd8;
    localparam logic [7:0] OFS_IRQ_MASK = 8'hd9;
    localparam logic [7:0] OFS_RX_BYTE_COUNT = 8'he2;
    localparam logic [7:0] OFS_CLOCK_DIV = 8'hea;
    // field positions in the frame high register
    localparam int FNH_VALID_BIT = 5;
    localparam int FNH_ERROR_BIT = 4;
    // field position of the start-of-frame event in the irq status register
    localparam int IRQ_SOF_BIT = 3;
    localparam int IRQ_W = 4;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [10:0] RST_FRAME = 11'h000;
    localparam logic [2:0] RST_EP_BITS = 3'h0;
    localparam logic [3:0] RST_IRQ = 4'h0;
    localparam logic [1:0] RST_DIV = 2'h0;
    localparam logic [6:0] RST_BYCT = 7'h00;
endpackage

// file: logic/uef_fifo.sv
// Purpose: one endpoint byte fifo, show-ahead head
// Assumes: push and pop may happen in one cycle
// Notes: storage has no reset, contents undefined after reset
`timescale 1ns/10ps
`default_nettype none
module uef_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // fill side
    input wire logic i_push,
    input wire logic [WIDTH-1:0] i_wdata,
    output logic o_full,
    // drain side
    input wire logic i_pop,
    output logic [WIDTH-1:0] o_head,
    output logic o_empty
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] level;
    logic [PTR_W-1:0] next_wr_ptr;
    logic [PTR_W-1:0] next_rd_ptr;
    logic [PTR_W:0] next_level;
    logic do_push;
    logic do_pop;

    assign o_full = (level == (PTR_W+1)'(DEPTH));
    assign o_empty = (level == '0);
    assign o_head = mem[rd_ptr];
    // overflow and underflow are dropped, not wrapped
    assign do_push = i_push && !o_full;
    assign do_pop = i_pop && !o_empty;

    always_comb
    begin
        next_wr_ptr = do_push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = do_pop ? rd_ptr + 1'b1 : rd_ptr;
        next_level = level;
        if (do_push && !do_pop)
        begin
            next_level = level + 1'b1;
        end
        else if (do_pop && !do_push)
        begin
            next_level = level - 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            level <= next_level;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (do_push)
        begin
            mem[wr_ptr] <= i_wdata;
        end
    end
endmodule
`default_nettype wire

// file: logic/uef_top.sv
// Purpose: endpoint enables, fifo window, byte count, frame number, clock divider
// Assumes: link strobes come from the serial engine on the same clock
// Notes: register reads answer one cycle after the read strobe
// Functional notes
// - one irq enable bit per endpoint, bits 2..0 for endpoints 2..0.
// - reserved bits of every register read as zero.
// - the window pushes or pops a byte of the selected endpoint fifo.
// - the 7-bit count shows bytes received after the data pid of the last packet of the selected endpoint.
// - frame number low 8 bits in one register, upper 3 bits in bits 2..0 of another.
// - a good sof loads the frame number, a corrupted one leaves it alone.
// - a good sof sets the valid bit at position 5.
// - a corrupted sof sets the error bit at position 4.
// - both sof check bits are re-evaluated on every sof.
// - the sof interrupt fires on the sof pid, before the check.
// - a 2-bit field in bits 1..0 selects the controller clock divide ratio.
// - both frame registers are read-only, reset to zero, writes ignored.
// - an endpoint flag sets only on an endpoint event with its enable set.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module uef_top #(
    parameter int FIFO_DEPTH = uef_pkg::FIFO_DEPTH
)
(
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_N,
    // register port
    input wire logic [7:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    // start of frame from the serial engine
    input wire logic I_SOF_PID,
    input wire logic I_SOF_DONE,
    input wire logic I_SOF_CRC_OK,
    input wire logic [10:0] I_SOF_FRAME,
    // received data packet
    input wire logic I_RX_PID,
    input wire logic I_RX_BYTE,
    input wire logic [7:0] I_RX_DATA,
    input wire logic I_RX_END,
    input wire logic [1:0] I_RX_EP,
    // transmit drain
    input wire logic I_TX_POP,
    input wire logic [1:0] I_TX_EP,
    output logic [7:0] O_TX_DATA,
    // endpoint status events
    input wire logic [2:0] I_EP_EVENT,
    // interrupt and clock
    output logic O_IRQ,
    output logic O_USB_CLK
);
    localparam int NEP = uef_pkg::NUM_EP;

    logic [2:0] ep_irq_enable;
    logic [1:0] endpoint_select;
    logic [10:0] frame_number;
    logic sof_frame_valid;
    logic sof_frame_error;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic [1:0] usb_clock_div_select;
    logic [1:0] div_count;
    logic usb_clk;
    logic [6:0] rx_run_count;
    logic [6:0] rx_byte_count [NEP];
    logic [7:0] rdata;
    logic [7:0] tx_data;
    logic irq;

    logic [2:0] next_ep_irq_enable;
    logic [1:0] next_endpoint_select;
    logic [10:0] next_frame_number;
    logic next_sof_frame_valid;
    logic next_sof_frame_error;
    logic [3:0] next_irq_status;
    logic [3:0] next_irq_mask;
    logic [1:0] next_usb_clock_div_select;
    logic [1:0] next_div_count;
    logic next_usb_clk;
    logic [6:0] next_rx_run_count;
    logic [6:0] next_rx_byte_count [NEP];
    logic [7:0] next_rdata;
    logic [7:0] next_tx_data;
    logic next_irq;

    logic [7:0] fifo_head [NEP];
    logic [NEP-1:0] fifo_empty;
    logic [7:0] window_byte;
    logic [6:0] sel_byte_count;
    logic sel_ok;
    logic fw_wr_window;
    logic fw_rd_window;

    assign sel_ok = (endpoint_select < 2'(NEP));
    assign fw_wr_window = I_WR && (I_ADDR == uef_pkg::OFS_FIFO_WINDOW);
    assign fw_rd_window = I_RD && (I_ADDR == uef_pkg::OFS_FIFO_WINDOW);
    assign window_byte = sel_ok ? fifo_head[endpoint_select] : uef_pkg::RST_BYTE;
    assign sel_byte_count = sel_ok ? rx_byte_count[endpoint_select] : uef_pkg::RST_BYCT;

    // a link byte and a firmware byte for one endpoint in one cycle: link wins
    for (genvar g = 0; g < NEP; g++)
    begin : g_ep
        logic rx_hit;
        logic fw_hit;
        logic tx_hit;
        assign rx_hit = I_RX_BYTE && (I_RX_EP == 2'(g));
        assign fw_hit = endpoint_select == 2'(g);
        assign tx_hit = I_TX_POP && (I_TX_EP == 2'(g));
        uef_fifo #(
            .WIDTH(uef_pkg::DATA_W),
            .DEPTH(FIFO_DEPTH)
        )
        u_fifo (
            .i_clk(I_CLK),
            .i_rst_n(I_RST_N),
            .i_push(rx_hit || (fw_wr_window && fw_hit)),
            .i_wdata(rx_hit ? I_RX_DATA : I_WDATA),
            .o_full(),
            .i_pop(tx_hit || (fw_rd_window && fw_hit)),
            .o_head(fifo_head[g]),
            .o_empty(fifo_empty[g])
        );
    end

    always_comb
    begin
        next_ep_irq_enable = ep_irq_enable;
        next_endpoint_select = endpoint_select;
        next_frame_number = frame_number;
        next_sof_frame_valid = sof_frame_valid;
        next_sof_frame_error = sof_frame_error;
        next_irq_status = irq_status;
        next_irq_mask = irq_mask;
        next_usb_clock_div_select = usb_clock_div_select;
        next_rx_run_count = rx_run_count;
        next_rx_byte_count = rx_byte_count;
        next_rdata = uef_pkg::RST_BYTE;
        next_tx_data = tx_data;
        // frame registers have no write decode at all
        if (I_WR)
        begin
            case (I_ADDR)
                uef_pkg::OFS_EP_IRQ_ENABLE: next_ep_irq_enable = I_WDATA[2:0];
                uef_pkg::OFS_EP_SELECT: next_endpoint_select = I_WDATA[1:0];
                uef_pkg::OFS_IRQ_MASK: next_irq_mask = I_WDATA[3:0];
                uef_pkg::OFS_CLOCK_DIV: next_usb_clock_div_select = I_WDATA[1:0];
                default:
                begin
                end
            endcase
        end
        if (I_SOF_DONE)
        begin
            if (I_SOF_CRC_OK)
            begin
                next_frame_number = I_SOF_FRAME;
                next_sof_frame_valid = 1'b1;
                next_sof_frame_error = 1'b0;
            end
            else
            begin
                next_sof_frame_valid = 1'b0;
                next_sof_frame_error = 1'b1;
            end
        end
        // count restarts at the data pid and is published at packet end
        if (I_RX_PID)
        begin
            next_rx_run_count = uef_pkg::RST_BYCT;
        end
        else if (I_RX_BYTE)
        begin
            next_rx_run_count = rx_run_count + 1'b1;
        end
        if (I_RX_END && (I_RX_EP < 2'(NEP)))
        begin
            next_rx_byte_count[I_RX_EP] = rx_run_count;
        end
        if (I_RD)
        begin
            case (I_ADDR)
                uef_pkg::OFS_FRAME_LOW: next_rdata = frame_number[7:0];
                uef_pkg::OFS_FRAME_HIGH:
                    next_rdata = {2'h0, sof_frame_valid, sof_frame_error, 1'b0,
                        frame_number[10:8]};
                uef_pkg::OFS_EP_IRQ_ENABLE: next_rdata = {5'h00, ep_irq_enable};
                uef_pkg::OFS_EP_SELECT: next_rdata = {6'h00, endpoint_select};
                uef_pkg::OFS_FIFO_WINDOW: next_rdata = window_byte;
                uef_pkg::OFS_IRQ_STATUS: next_rdata = {4'h0, irq_status};
                uef_pkg::OFS_IRQ_MASK: next_rdata = {4'h0, irq_mask};
                uef_pkg::OFS_RX_BYTE_COUNT: next_rdata = {1'b0, sel_byte_count};
                uef_pkg::OFS_CLOCK_DIV: next_rdata = {6'h00, usb_clock_div_select};
                default: next_rdata = uef_pkg::RST_BYTE;
            endcase
            if (I_ADDR == uef_pkg::OFS_IRQ_STATUS)
            begin
                next_irq_status = uef_pkg::RST_IRQ;
            end
        end
        // sets come after the read clear so an event in that cycle survives
        next_irq_status[2:0] = next_irq_status[2:0] | (I_EP_EVENT & ep_irq_enable);
        if (I_SOF_PID)
        begin
            next_irq_status[uef_pkg::IRQ_SOF_BIT] = 1'b1;
        end
        next_irq = |(next_irq_status & next_irq_mask);
        if (I_TX_POP && (I_TX_EP < 2'(NEP)))
        begin
            next_tx_data = fifo_head[I_TX_EP];
        end
    end

    // divided clock: half period of select+1 cycles, ratio 2*(select+1)
    always_comb
    begin
        next_div_count = div_count + 1'b1;
        next_usb_clk = usb_clk;
        if (div_count >= usb_clock_div_select)
        begin
            next_div_count = uef_pkg::RST_DIV;
            next_usb_clk = !usb_clk;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            ep_irq_enable <= uef_pkg::RST_EP_BITS;
            endpoint_select <= uef_pkg::RST_DIV;
            frame_number <= uef_pkg::RST_FRAME;
            sof_frame_valid <= 1'b0;
            sof_frame_error <= 1'b0;
            irq_status <= uef_pkg::RST_IRQ;
            irq_mask <= uef_pkg::RST_IRQ;
            usb_clock_div_select <= uef_pkg::RST_DIV;
            div_count <= uef_pkg::RST_DIV;
            usb_clk <= 1'b0;
            rx_run_count <= uef_pkg::RST_BYCT;
            for (int i = 0; i < NEP; i++)
            begin
                rx_byte_count[i] <= uef_pkg::RST_BYCT;
            end
            rdata <= uef_pkg::RST_BYTE;
            tx_data <= uef_pkg::RST_BYTE;
            irq <= 1'b0;
        end
        else
        begin
            ep_irq_enable <= next_ep_irq_enable;
            endpoint_select <= next_endpoint_select;
            frame_number <= next_frame_number;
            sof_frame_valid <= next_sof_frame_valid;
            sof_frame_error <= next_sof_frame_error;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            usb_clock_div_select <= next_usb_clock_div_select;
            div_count <= next_div_count;
            usb_clk <= next_usb_clk;
            rx_run_count <= next_rx_run_count;
            rx_byte_count <= next_rx_byte_count;
            rdata <= next_rdata;
            tx_data <= next_tx_data;
            irq <= next_irq;
        end
    end

    assign O_RDATA = rdata;
    assign O_TX_DATA = tx_data;
    assign O_IRQ = irq;
    assign O_USB_CLK = usb_clk;

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    sequence s_wr_enable;
        I_WR && (I_ADDR == uef_pkg::OFS_EP_IRQ_ENABLE);
    endsequence
    sequence s_rd_enable;
        I_RD && (I_ADDR == uef_pkg::OFS_EP_IRQ_ENABLE);
    endsequence
    sequence s_good_sof;
        I_SOF_DONE && I_SOF_CRC_OK;
    endsequence
    sequence s_bad_sof;
        I_SOF_DONE && !I_SOF_CRC_OK;
    endsequence

    AST_ENABLE_READBACK: assert property (s_wr_enable ##1 !I_WR ##1 s_rd_enable |=>
        O_RDATA[2:0] == $past(I_WDATA[2:0], 3))
        else $error("enable readback differs from write");
    AST_RESERVED_ZERO: assert property ($past(I_RD) &&
        ($past(I_ADDR) == uef_pkg::OFS_EP_IRQ_ENABLE || $past(I_ADDR) == uef_pkg::OFS_FRAME_HIGH)
        |-> (O_RDATA[7:6] == 2'h0) && (O_RDATA[3] == 1'b0))
        else $error("reserved bits read nonzero");
    AST_FRAME_LOAD: assert property (s_good_sof |=>
        (frame_number == $past(I_SOF_FRAME)) && sof_frame_valid && !sof_frame_error)
        else $error("good sof not loaded");
    AST_FRAME_KEEP: assert property (s_bad_sof |=>
        $stable(frame_number))
        else $error("corrupted sof changed frame number");
    AST_VALID_SET: assert property (s_good_sof |=> ##1 sof_frame_valid || $past(I_SOF_DONE))
        else $error("valid bit not held after good sof");
    AST_ERROR_SET: assert property (s_bad_sof |=> sof_frame_error && !sof_frame_valid)
        else $error("error bit not set on corrupted sof");
    AST_SOF_IRQ: assert property (I_SOF_PID |=> irq_status[uef_pkg::IRQ_SOF_BIT])
        else $error("sof interrupt missed at pid");
    AST_EP_GATE: assert property (!irq_status[0] && !(I_EP_EVENT[0] && ep_irq_enable[0])
        |=> !irq_status[0])
        else $error("endpoint flag set without enabled event");
    AST_FRAME_RO: assert property (I_WR && (I_ADDR == uef_pkg::OFS_FRAME_LOW) && !I_SOF_DONE
        |=> $stable(frame_number))
        else $error("write changed frame number");
    AST_BYTE_COUNT: assert property (I_RX_END && (I_RX_EP == 2'h0) |=>
        rx_byte_count[0] == $past(rx_run_count))
        else $error("byte count not published");
    AST_DIV_TOGGLE: assert property (usb_clock_div_select == 2'h0 && $past(usb_clock_div_select)
        == 2'h0 && div_count == 2'h0 |=> usb_clk != $past(usb_clk))
        else $error("divide by two does not toggle");
endmodule
`default_nettype wire

// file: tb/uef_link_model.sv
// Purpose: serial engine stand-in that drives the link strobes of the block
// Assumes: runs on the block clock, strobes are one cycle long
// Notes: unqualified data lines carry inverted values, except o_rx_ep, which holds its endpoint from pid to packet end
`timescale 1ns/10ps
`default_nettype none
module uef_link_model
(
    // clock
    input wire logic i_clk,
    // start of frame
    output logic o_sof_pid,
    output logic o_sof_done,
    output logic o_sof_ok,
    output logic [10:0] o_sof_frame,
    // receive side
    output logic o_rx_pid,
    output logic o_rx_byte,
    output logic [7:0] o_rx_data,
    output logic o_rx_end,
    output logic [1:0] o_rx_ep,
    // transmit drain and endpoint events
    output logic o_tx_pop,
    output logic [1:0] o_tx_ep,
    output logic [2:0] o_ep_event
);
    initial
    begin
        {o_sof_pid, o_sof_done, o_sof_ok, o_rx_pid, o_rx_byte, o_rx_end} = '0;
        {o_sof_frame, o_rx_data, o_rx_ep, o_tx_pop, o_tx_ep, o_ep_event} = '0;
    end
    task automatic pid();
        @(posedge i_clk);
        o_sof_pid <= 1'b1;
        @(posedge i_clk);
        o_sof_pid <= 1'b0;
    endtask
    // a stalled engine may leave any gap between pid and check
    task automatic check(input logic ok, input logic [10:0] f);
        @(posedge i_clk);
        {o_sof_done, o_sof_ok, o_sof_frame} <= {1'b1, ok, f};
        @(posedge i_clk);
        {o_sof_done, o_sof_ok, o_sof_frame} <= {1'b0, ~ok, ~f};
    endtask
    task automatic rx_start(input logic [1:0] ep);
        @(posedge i_clk);
        {o_rx_pid, o_rx_ep} <= {1'b1, ep};
        @(posedge i_clk);
        o_rx_pid <= 1'b0;
    endtask
    task automatic rx_put(input logic [7:0] b);
        @(posedge i_clk);
        {o_rx_byte, o_rx_data} <= {1'b1, b};
        @(posedge i_clk);
        {o_rx_byte, o_rx_data} <= {1'b0, ~b};
    endtask
    task automatic rx_stop();
        @(posedge i_clk);
        o_rx_end <= 1'b1;
        @(posedge i_clk);
        {o_rx_end, o_rx_ep} <= {1'b0, ~o_rx_ep};
    endtask
    task automatic tx(input logic [1:0] ep);
        @(posedge i_clk);
        {o_tx_pop, o_tx_ep} <= {1'b1, ep};
        @(posedge i_clk);
        {o_tx_pop, o_tx_ep} <= {1'b0, ~ep};
    endtask
    task automatic event_pulse(input logic [2:0] v);
        @(posedge i_clk);
        o_ep_event <= v;
        @(posedge i_clk);
        o_ep_event <= 3'h0;
    endtask
endmodule
`default_nettype wire

// file: tb/uef_top_bench.sv
// Purpose: self-checking bench for the endpoint and frame register block
// Assumes: read data stand in the cycle after the read strobe only
// Notes: a monitor checks read data against the oldest queued note
`timescale 1ns/10ps
`default_nettype none
module uef_top_bench;
    logic I_CLK = 1'b0;
    logic I_RST_N;
    logic [7:0] I_ADDR;
    logic [7:0] I_WDATA;
    logic I_WR;
    logic I_RD;
    logic [7:0] O_RDATA, O_TX_DATA, rx_data;
    logic O_IRQ, O_USB_CLK, sof_pid, sof_done, sof_ok, rx_pid, rx_byte, rx_end, tx_pop;
    logic [10:0] sof_frame, f;
    logic [1:0] rx_ep, tx_ep;
    logic [2:0] ep_event;
    int miscompares = 0;
    int comparisons = 0;
    int n;
    logic [31:0] seed = 32'h1604;
    logic [15:0] note;
    logic [15:0] notes[$];
    logic [7:0] bytes[$];
    logic rd_pending = 1'b0;

    always #5 I_CLK = ~I_CLK;

    uef_link_model link (.i_clk(I_CLK), .o_sof_pid(sof_pid), .o_sof_done(sof_done),
        .o_sof_ok(sof_ok), .o_sof_frame(sof_frame), .o_rx_pid(rx_pid), .o_rx_byte(rx_byte),
        .o_rx_data(rx_data), .o_rx_end(rx_end), .o_rx_ep(rx_ep), .o_tx_pop(tx_pop),
        .o_tx_ep(tx_ep), .o_ep_event(ep_event));
    uef_top uut (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
        .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_SOF_PID(sof_pid),
        .I_SOF_DONE(sof_done), .I_SOF_CRC_OK(sof_ok), .I_SOF_FRAME(sof_frame),
        .I_RX_PID(rx_pid), .I_RX_BYTE(rx_byte), .I_RX_DATA(rx_data), .I_RX_END(rx_end),
        .I_RX_EP(rx_ep), .I_TX_POP(tx_pop), .I_TX_EP(tx_ep), .O_TX_DATA(O_TX_DATA),
        .I_EP_EVENT(ep_event), .O_IRQ(O_IRQ), .O_USB_CLK(O_USB_CLK));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk8(input string name, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic chk1(input string name, input logic e, input logic g);
        chk8(name, {7'h00, e}, {7'h00, g});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge I_CLK);
        {I_WR, I_ADDR, I_WDATA} <= {1'b1, a, d};
        @(posedge I_CLK);
        I_WR <= 1'b0;
    endtask
    // the note goes in before the strobe so the monitor never finds an empty queue
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge I_CLK);
        notes.push_back({a, e});
        {I_RD, I_ADDR} <= {1'b1, a};
        @(posedge I_CLK);
        I_RD <= 1'b0;
    endtask
    task automatic div_chk(input logic [1:0] s);
        logic p;
        wr(uef_pkg::OFS_CLOCK_DIV, {6'h00, s});
        repeat (3) @(posedge I_CLK);
        for (int k = 0; k < 2; k++)
        begin
            #1 p = O_USB_CLK;
            n = 0;
            while (O_USB_CLK === p && n < 20)
            begin
                @(posedge I_CLK);
                #1 n++;
            end
        end
        chk8("usb_clk_half_period", {6'h00, s} + 8'h01, 8'(n));
    endtask
    task automatic conclude();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge I_CLK)
    begin
        if (rd_pending)
        begin
            note = notes.pop_front();
            chk8($sformatf("rdata_%h", note[15:8]), note[7:0], O_RDATA);
        end
        rd_pending <= I_RD;
    end

    initial
    begin
        repeat (20000) @(posedge I_CLK);
        miscompares++;
        conclude();
    end

    initial
    begin
        {I_RST_N, I_WR, I_RD, I_ADDR, I_WDATA} = '0;
        repeat (6) @(posedge I_CLK);
        I_RST_N <= 1'b1;
        rd(uef_pkg::OFS_FRAME_LOW, 8'h00);
        rd(uef_pkg::OFS_FRAME_HIGH, 8'h00);
        rd(uef_pkg::OFS_EP_IRQ_ENABLE, 8'h00);
        rd(uef_pkg::OFS_RX_BYTE_COUNT, 8'h00);
        rd(uef_pkg::OFS_CLOCK_DIV, 8'h00);
        rd(8'h00, 8'h00);
        $display("test done: reset values");
        wr(uef_pkg::OFS_EP_IRQ_ENABLE, 8'h07);
        rd(uef_pkg::OFS_EP_IRQ_ENABLE, 8'h07);
        wr(uef_pkg::OFS_EP_IRQ_ENABLE, 8'h05);
        rd(uef_pkg::OFS_EP_IRQ_ENABLE, 8'h05);
        for (int s = 0; s < 4; s++)
            div_chk(2'(s));
        wr(uef_pkg::OFS_CLOCK_DIV, 8'h02);
        rd(uef_pkg::OFS_CLOCK_DIV, 8'h02);
        $display("test done: enables and divider");
        wr(uef_pkg::OFS_IRQ_MASK, 8'h0f);
        seed = lfsr(seed);
        f = seed[10:0];
        link.pid();
        @(posedge I_CLK);
        #1 chk1("irq_on_pid", 1'b1, O_IRQ);
        rd(uef_pkg::OFS_FRAME_HIGH, 8'h00);
        link.check(1'b1, f);
        rd(uef_pkg::OFS_FRAME_LOW, f[7:0]);
        rd(uef_pkg::OFS_FRAME_HIGH, {5'h04, f[10:8]});
        wr(uef_pkg::OFS_FRAME_LOW, ~f[7:0]);
        link.pid();
        link.check(1'b0, ~f);
        rd(uef_pkg::OFS_FRAME_LOW, f[7:0]);
        rd(uef_pkg::OFS_FRAME_HIGH, {5'h02, f[10:8]});
        link.pid();
        link.check(1'b1, ~f);
        rd(uef_pkg::OFS_FRAME_HIGH, {5'h04, ~f[10:8]});
        rd(uef_pkg::OFS_FRAME_LOW, ~f[7:0]);
        rd(uef_pkg::OFS_IRQ_STATUS, 8'h08);
        @(posedge I_CLK);
        #1 chk1("irq_after_clear", 1'b0, O_IRQ);
        $display("test done: start of frame");
        wr(uef_pkg::OFS_EP_SELECT, 8'h01);
        seed = lfsr(seed);
        n = 3 + int'(seed[1:0]);
        link.rx_start(2'h1);
        for (int i = 0; i < n; i++)
        begin
            seed = lfsr(seed);
            bytes.push_back(seed[7:0]);
            link.rx_put(seed[7:0]);
        end
        link.rx_stop();
        link.rx_start(2'h0);
        link.rx_stop();
        rd(uef_pkg::OFS_RX_BYTE_COUNT, 8'(n));
        foreach (bytes[i])
            rd(uef_pkg::OFS_FIFO_WINDOW, bytes[i]);
        wr(uef_pkg::OFS_EP_SELECT, 8'h03);
        rd(uef_pkg::OFS_RX_BYTE_COUNT, 8'h00);
        rd(uef_pkg::OFS_FIFO_WINDOW, 8'h00);
        wr(uef_pkg::OFS_EP_SELECT, 8'h00);
        rd(uef_pkg::OFS_RX_BYTE_COUNT, 8'h00);
        wr(uef_pkg::OFS_FIFO_WINDOW, 8'h3c);
        wr(uef_pkg::OFS_FIFO_WINDOW, 8'hc3);
        link.tx(2'h0);
        #1 chk8("tx_data", 8'h3c, O_TX_DATA);
        link.tx(2'h0);
        #1 chk8("tx_data", 8'hc3, O_TX_DATA);
        $display("test done: fifo window and count");
        wr(uef_pkg::OFS_EP_IRQ_ENABLE, 8'h02);
        link.event_pulse(3'h7);
        #1 chk1("irq_on_event", 1'b1, O_IRQ);
        rd(uef_pkg::OFS_IRQ_STATUS, 8'h02);
        @(posedge I_CLK);
        #1 chk1("irq_after_clear", 1'b0, O_IRQ);
        wr(uef_pkg::OFS_EP_IRQ_ENABLE, 8'h05);
        link.event_pulse(3'h7);
        rd(uef_pkg::OFS_IRQ_STATUS, 8'h05);
        $display("test done: endpoint events");
        // let the monitor take the last read data before reset clears it
        @(posedge I_CLK);
        I_RST_N <= 1'b0;
        repeat (2) @(posedge I_CLK);
        I_RST_N <= 1'b1;
        rd(uef_pkg::OFS_EP_IRQ_ENABLE, 8'h00);
        rd(uef_pkg::OFS_FRAME_LOW, 8'h00);
        repeat (2) @(posedge I_CLK);
        $display("test done: second reset");
        conclude();
    end
endmodule
`default_nettype wire
